// ===== hwa_pkg.sv
// Constants, types and helper functions for the hierarchical memory arbiter.
// Assumes one memory clock at 200 MHz shared by requesters and controller.
package hwa_pkg;

   // ==================================================================
   // Requesters
   localparam int UID_W = 4;
   localparam int NUNITS = 10;
   localparam int NLEVELS = 5;
   localparam int NLOW = 5;
   localparam int NRAISE = 4;
   localparam int NRT = 4;
   localparam logic [UID_W-1:0] U_CPU = 4'h0;
   localparam logic [UID_W-1:0] U_VOUT = 4'h1;
   localparam logic [UID_W-1:0] U_ICOP = 4'h2;
   localparam logic [UID_W-1:0] U_VIN = 4'h3;
   localparam logic [UID_W-1:0] U_PCI = 4'h4;
   localparam logic [UID_W-1:0] U_DEC = 4'h5;
   localparam logic [UID_W-1:0] U_AIN = 4'h6;
   localparam logic [UID_W-1:0] U_AOUT = 4'h7;
   localparam logic [UID_W-1:0] U_DISC = 4'h8;
   localparam logic [UID_W-1:0] U_BOOT = 4'h9;
   localparam logic [NUNITS-1:0] BACK2BACK = 10'h001;
   localparam logic [UID_W-1:0] RAISE_UNIT [NRAISE] = '{U_VOUT, U_VIN, U_PCI, U_DEC};
   localparam logic [UID_W-1:0] RT_UNIT [NRT] = '{U_VOUT, U_VIN, U_AIN, U_AOUT};

   // ==================================================================
   // Weight field layout
   localparam int WW = 3;
   localparam int BW_REG_W = 26;
   localparam int F_CPU = 16;
   localparam int F_LVL2 = 14;
   localparam int F_VOUT = 12;
   localparam int F_LVL3 = 10;
   localparam int F_ICOP = 8;
   localparam int F_LVL4 = 6;
   localparam int F_VIN = 5;
   localparam int F_LVL5 = 3;
   localparam int F_PCI = 1;
   localparam int F_LVL6 = 0;
   localparam logic [WW-1:0] W_1 = 3'h1;
   localparam logic [WW-1:0] W_2 = 3'h2;
   localparam logic [WW-1:0] W_3 = 3'h3;
   localparam logic [WW-1:0] W_5 = 3'h5;
   localparam logic [WW-1:0] W_7 = 3'h7;

   // ==================================================================
   // Timing
   localparam int CNT_W = 6;
   localparam int WAIT_W = 14;
   localparam logic [CNT_W-1:0] TXN_CYCLES = 6'h14;
   localparam logic [CNT_W-1:0] REORDER_CYCLES = 6'h0a;
   localparam logic [CNT_W-1:0] REFRESH_LAST = 6'h12;
   localparam logic [CNT_W-1:0] DECIDE_RD = 6'h0e;
   localparam logic [CNT_W-1:0] DECIDE_WR = 6'h10;
   localparam logic [CNT_W-1:0] SKEW_LO = 6'h01;
   localparam logic [CNT_W-1:0] SKEW_HI = 6'h02;
   localparam logic [15:0] RAISE_STEP = 16'h0010;
   localparam logic [6:0] BLOCK_BYTES = 7'h40;
   localparam real CLK_HZ = 200.0e6;
   localparam real REFRESH_WINDOW_S = 0.064;
   localparam real REFRESH_OPS = 4096.0;
   localparam int REFRESH_INTERVAL_CYC = $rtoi(REFRESH_WINDOW_S * CLK_HZ / REFRESH_OPS);
   localparam int REF_W = 12;
   localparam logic [REF_W-1:0] REF_LAST = REF_W'(REFRESH_INTERVAL_CYC - 1);

   // ==================================================================
   // Types
   typedef enum logic [2:0] {
      HWA_R1 = 3'h0,
      HWA_R5_4 = 3'h1,
      HWA_R4_3 = 3'h2,
      HWA_R3_2 = 3'h3,
      HWA_R2_1 = 3'h4
   } hwa_ratio_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_XFER = 2'h1,
      ST_REFRESH = 2'h2
   } hwa_state_e;

   typedef struct packed {
      logic valid;
      logic [UID_W-1:0] unit;
      logic write;
      logic [6:0] bytes;
   } hwa_grant_s;

   // ==================================================================
   // Weight decoding; code zero always means weight one
   function automatic logic [WW-1:0] wt_123(input logic [1:0] c);
      case (c)
         2'h0: return W_1;
         2'h1: return W_2;
         default: return W_3;
      endcase
   endfunction : wt_123

   function automatic logic [WW-1:0] wt_135(input logic [1:0] c);
      case (c)
         2'h0: return W_1;
         2'h1: return W_3;
         default: return W_5;
      endcase
   endfunction : wt_135

   function automatic logic [WW-1:0] wt_1357(input logic [1:0] c);
      case (c)
         2'h0: return W_1;
         2'h1: return W_3;
         2'h2: return W_5;
         default: return W_7;
      endcase
   endfunction : wt_1357

   function automatic logic [WW-1:0] wt_12(input logic c);
      return c ? W_2 : W_1;
   endfunction : wt_12

   // Decision point slips later as the processor runs faster
   function automatic logic [CNT_W-1:0] ratio_skew(input hwa_ratio_e c);
      case (c)
         HWA_R5_4, HWA_R4_3: return SKEW_LO;
         HWA_R3_2, HWA_R2_1: return SKEW_HI;
         default: return '0;
      endcase
   endfunction : ratio_skew

   // Raise delay in processor clocks, converted to memory cycles, rounded up
   function automatic logic [WAIT_W-1:0] raise_cycles(input logic [7:0] r, input hwa_ratio_e c);
      logic [15:0] t;
      logic [15:0] q;
      t = 16'(r) * RAISE_STEP;
      case (c)
         HWA_R5_4: q = (t * 16'h0004 + 16'h0004) / 16'h0005;
         HWA_R4_3: q = (t * 16'h0003 + 16'h0003) / 16'h0004;
         HWA_R3_2: q = (t * 16'h0002 + 16'h0002) / 16'h0003;
         HWA_R2_1: q = (t + 16'h0001) / 16'h0002;
         default: q = t;
      endcase
      return q[WAIT_W-1:0];
   endfunction : raise_cycles

endpackage : hwa_pkg

// ===== hwa_wrr.sv
// Weighted round-robin picker with credit counters for one arbitration level.
// Assumes advance is high only in a cycle whose pick is actually taken.
module hwa_wrr
   import hwa_pkg::*;
#(
   parameter int N = 2,
   parameter int W = 3
) (
   input logic clk,
   input logic rst,
   input logic [N-1:0] req,
   input logic [N-1:0][W-1:0] weight,
   input logic advance,
   output logic [N-1:0] pick
);
   localparam int PW = (N > 1) ? $clog2(N) : 1;

   if (N < 2 || W < 1) begin : g_chk
      $error("hwa_wrr needs N of at least 2 and W of at least 1");
   end

   logic [N-1:0][W-1:0] credit_r;
   logic [N-1:0][W-1:0] eff;
   logic [PW-1:0] ptr_r;
   logic [PW-1:0] sel;
   logic found;
   logic reload;

   // ==================================================================
   // Pick
   always_comb begin
      int idx;
      idx = 0;
      reload = 1'b1;
      for (int k = 0; k < N; k++) begin
         if (req[k] && credit_r[k] != '0) begin
            reload = 1'b0;
         end
      end
      eff = reload ? weight : credit_r;
      found = 1'b0;
      sel = ptr_r;
      for (int i = 0; i < N; i++) begin
         idx = (int'(ptr_r) + i) % N;
         if (!found && req[idx] && eff[idx] != '0) begin
            found = 1'b1;
            sel = PW'(idx);
         end
      end
      // Unused share falls to whoever is still asking
      for (int i = 0; i < N; i++) begin
         idx = (int'(ptr_r) + i) % N;
         if (!found && req[idx]) begin
            found = 1'b1;
            sel = PW'(idx);
         end
      end
      pick = found ? ({{(N-1){1'b0}}, 1'b1} << sel) : '0;
   end

   // ==================================================================
   // Credit and pointer update
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         credit_r <= '0;
         ptr_r <= '0;
      end else if (advance && found) begin
         credit_r <= eff;
         if (eff[sel] != '0) begin
            credit_r[sel] <= eff[sel] - 1'b1;
         end
         if (eff[sel] <= W'(1)) begin
            ptr_r <= (sel == PW'(N - 1)) ? '0 : sel + 1'b1;
         end
      end
   end

endmodule : hwa_wrr

// ===== hwa_arbiter.sv
// Hierarchical weighted memory arbiter: six-level grant tree, raise-delay
// promotion, refresh slots and real-time latency flags.
// Assumes requesters and memory controller run on clk; no synchronisers.
//
// Summary of operation
// - Each transaction holds the bus twenty cycles
// - Each refresh holds the bus nineteen cycles
// - Reordered first processor transaction adds ten cycles
// - Only four units have programmable raise delay
// - Raise delay converted through processor clock ratio
// - Every transaction moves one 64-byte block
// - Decision point near cycle sixteen, read/write dependent
// - Ratio shifts decision; re-requests before it compete
// - Non back-to-back units win at most occasionally
// - Unused real-time slots pass to lower units
// - Weights are minimum shares; idle bandwidth shared
// - Disabled unit takes no slot, weight zero
// - Real-time units flag late grant overflow/underflow
// - Refresh inserted 4096 times per 64 ms
// - Six fixed levels, unit against lower aggregate
// - Weight fields decode to documented weight sets
// - Zero weight register gives weight one at every level except the fixed lowest one
// - Lowest level: decoder two, others one
module hwa_arbiter
   import hwa_pkg::*;
#(
   parameter int RAISE_W = 8
) (
   input logic clk,
   input logic rst,
   input logic [NUNITS-1:0] req,
   input logic [NUNITS-1:0] req_write,
   input logic cpu_reorder,
   input logic [NUNITS-1:0] unit_enable,
   input logic [BW_REG_W-1:0] bandwidth_weight_reg,
   input logic [NRAISE-1:0][RAISE_W-1:0] priority_raise_delay_reg,
   input hwa_ratio_e clk_ratio,
   input logic [NRT-1:0][WAIT_W-1:0] rt_latency_limit,
   input logic [NRT-1:0] rt_fault_clear,
   output hwa_grant_s grant,
   output logic [NUNITS-1:0] ack,
   output logic [NUNITS-1:0] done,
   output logic refresh_active,
   output logic [NRT-1:0] rt_fault
);

   if (RAISE_W < 1 || RAISE_W > 8) begin : g_chk
      $error("hwa_arbiter supports RAISE_W from 1 to 8");
   end

   localparam logic [NUNITS-1:0] ONE = {{(NUNITS-1){1'b0}}, 1'b1};

   hwa_state_e state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] len_r;
   logic cur_wr_r;
   logic [UID_W-1:0] cur_r;
   logic next_v_r;
   logic [UID_W-1:0] next_u_r;
   logic next_wr_r;
   logic next_ro_r;
   logic [NUNITS-1:0] inflight_r;
   logic [NUNITS-1:0][WAIT_W-1:0] wait_r;
   logic [REF_W-1:0] ref_tmr_r;
   logic ref_pend_r;
   hwa_grant_s grant_r;
   logic [NUNITS-1:0] ack_r;
   logic [NUNITS-1:0] done_r;
   logic [NRT-1:0] rt_fault_r;

   logic [NUNITS-1:0] elig;
   logic [NUNITS-1:0] promo;
   logic [NUNITS-1:0] win;
   logic [UID_W-1:0] win_idx;
   logic [NUNITS-1:0] ack_nxt;
   logic [NUNITS-1:0] done_nxt;
   logic [CNT_W-1:0] decide_pt;
   logic decide_now;
   logic xfer_end;
   logic ref_end;
   logic ref_start;
   logic start_next;
   logic ref_tick;

   // ==================================================================
   // Eligibility
   // Units other than the processor are masked while their block is
   // outstanding; this caps how often they can win.
   assign elig = req & unit_enable & (~inflight_r | BACK2BACK);

   // ==================================================================
   // Weights
   logic [NLEVELS-1:0][WW-1:0] up_w;
   logic [NLEVELS-1:0][WW-1:0] lo_w;
   logic [NLEVELS-1:0][1:0][WW-1:0] lvl_w;
   logic [NLOW-1:0][WW-1:0] low_w;

   always_comb begin
      up_w[0] = wt_123(bandwidth_weight_reg[F_CPU +: 2]);
      lo_w[0] = wt_123(bandwidth_weight_reg[F_LVL2 +: 2]);
      up_w[1] = wt_135(bandwidth_weight_reg[F_VOUT +: 2]);
      lo_w[1] = wt_1357(bandwidth_weight_reg[F_LVL3 +: 2]);
      up_w[2] = wt_1357(bandwidth_weight_reg[F_ICOP +: 2]);
      lo_w[2] = wt_135(bandwidth_weight_reg[F_LVL4 +: 2]);
      up_w[3] = wt_12(bandwidth_weight_reg[F_VIN]);
      lo_w[3] = wt_135(bandwidth_weight_reg[F_LVL5 +: 2]);
      up_w[4] = wt_135(bandwidth_weight_reg[F_PCI +: 2]);
      lo_w[4] = wt_12(bandwidth_weight_reg[F_LVL6]);
      for (int k = 0; k < NLEVELS; k++) begin
         lvl_w[k][0] = unit_enable[k] ? up_w[k] : '0;
         lvl_w[k][1] = (|(unit_enable >> (k + 1))) ? lo_w[k] : '0;
      end
      for (int j = 0; j < NLOW; j++) begin
         low_w[j] = !unit_enable[int'(U_DEC) + j] ? '0 : (j == 0) ? W_2 : W_1;
      end
   end

   // ==================================================================
   // Grant tree: each level sets its unit against everything below
   logic [NLEVELS-1:0][1:0] lvl_pick;
   logic [NLEVELS-1:0] lvl_adv;
   logic [NLOW-1:0] low_pick;
   logic low_adv;

   for (genvar k = 0; k < NLEVELS; k++) begin : g_lvl
      hwa_wrr #(
         .N(2),
         .W(WW)
      ) u_wrr (
         .clk(clk),
         .rst(rst),
         .req({|(elig >> (k + 1)), elig[k]}),
         .weight(lvl_w[k]),
         .advance(lvl_adv[k]),
         .pick(lvl_pick[k])
      );
   end

   hwa_wrr #(
      .N(NLOW),
      .W(WW)
   ) u_low (
      .clk(clk),
      .rst(rst),
      .req(elig[U_DEC +: NLOW]),
      .weight(low_w),
      .advance(low_adv),
      .pick(low_pick)
   );

   // ==================================================================
   // Winner selection
   logic [NRAISE-1:0][WAIT_W-1:0] raise_thr;

   always_comb begin
      logic reach;
      reach = 1'b1;
      promo = '0;
      for (int j = 0; j < NRAISE; j++) begin
         raise_thr[j] = raise_cycles(8'(priority_raise_delay_reg[j]), clk_ratio);
         if (elig[RAISE_UNIT[j]] && wait_r[RAISE_UNIT[j]] >= raise_thr[j]) begin
            promo[RAISE_UNIT[j]] = 1'b1;
         end
      end
      win = '0;
      lvl_adv = '0;
      low_adv = 1'b0;
      if (promo != '0) begin
         // Promoted requests bypass the tree and leave its credits alone
         win = promo & (~promo + ONE);
      end else begin
         for (int k = 0; k < NLEVELS; k++) begin
            if (reach) begin
               if (lvl_pick[k][0]) begin
                  win[k] = 1'b1;
                  reach = 1'b0;
               end else if (!lvl_pick[k][1]) begin
                  reach = 1'b0;
               end
               lvl_adv[k] = decide_now && (lvl_pick[k] != '0);
            end
         end
         if (reach) begin
            win[U_DEC +: NLOW] = low_pick;
            low_adv = decide_now;
         end
      end
      win_idx = '0;
      for (int u = 0; u < NUNITS; u++) begin
         if (win[u]) begin
            win_idx = UID_W'(u);
         end
      end
   end

   // ==================================================================
   // Decision timing
   assign decide_pt = (cur_wr_r ? DECIDE_WR : DECIDE_RD) + ratio_skew(clk_ratio);
   assign decide_now = !next_v_r && (elig != '0)
      && (state_r != ST_XFER || cnt_r >= decide_pt);
   assign ack_nxt = decide_now ? win : '0;
   assign xfer_end = state_r == ST_XFER && cnt_r == len_r - 1'b1;
   assign ref_end = state_r == ST_REFRESH && cnt_r == REFRESH_LAST;
   assign ref_start = ref_pend_r && (state_r == ST_IDLE || xfer_end);
   assign start_next = next_v_r && !ref_start
      && (state_r == ST_IDLE || xfer_end || ref_end);
   assign done_nxt = xfer_end ? (ONE << cur_r) : '0;

   // ==================================================================
   // Waiting time per requester
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_r <= '0;
      end else begin
         for (int u = 0; u < NUNITS; u++) begin
            if (!elig[u] || ack_nxt[u]) begin
               wait_r[u] <= '0;
            end else if (wait_r[u] != '1) begin
               wait_r[u] <= wait_r[u] + 1'b1;
            end
         end
      end
   end

   // ==================================================================
   // Refresh schedule
   assign ref_tick = ref_tmr_r == REF_LAST;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_tmr_r <= '0;
      end else begin
         ref_tmr_r <= ref_tick ? '0 : ref_tmr_r + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_pend_r <= 1'b0;
      end else begin
         ref_pend_r <= ref_tick | (ref_pend_r & ~ref_start);
      end
   end

   // ==================================================================
   // Bus state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               cnt_r <= '0;
               if (ref_start) begin
                  state_r <= ST_REFRESH;
               end else if (start_next) begin
                  state_r <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (!xfer_end) begin
                  cnt_r <= cnt_r + 1'b1;
               end else begin
                  cnt_r <= '0;
                  if (ref_start) begin
                     state_r <= ST_REFRESH;
                  end else if (!start_next) begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            ST_REFRESH: begin
               if (!ref_end) begin
                  cnt_r <= cnt_r + 1'b1;
               end else begin
                  cnt_r <= '0;
                  state_r <= start_next ? ST_XFER : ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               cnt_r <= '0;
            end
         endcase
      end
   end

   // ==================================================================
   // Decided request waiting for the bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         next_v_r <= 1'b0;
         next_u_r <= '0;
         next_wr_r <= 1'b0;
         next_ro_r <= 1'b0;
      end else if (decide_now) begin
         next_v_r <= 1'b1;
         next_u_r <= win_idx;
         next_wr_r <= req_write[win_idx];
         next_ro_r <= (win_idx == U_CPU) && cpu_reorder;
      end else if (start_next) begin
         next_v_r <= 1'b0;
      end
   end

   // ==================================================================
   // Transaction in progress
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_r <= '0;
         cur_wr_r <= 1'b0;
         len_r <= TXN_CYCLES;
      end else if (start_next) begin
         cur_r <= next_u_r;
         cur_wr_r <= next_wr_r;
         len_r <= TXN_CYCLES + (next_ro_r ? REORDER_CYCLES : '0);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         inflight_r <= '0;
      end else begin
         inflight_r <= (inflight_r & ~done_nxt) | ack_nxt;
      end
   end

   // ==================================================================
   // Outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         grant_r <= '0;
         ack_r <= '0;
         done_r <= '0;
      end else begin
         grant_r.valid <= start_next;
         grant_r.unit <= next_u_r;
         grant_r.write <= next_wr_r;
         grant_r.bytes <= BLOCK_BYTES;
         ack_r <= ack_nxt;
         done_r <= done_nxt;
      end
   end

   // Late grants to a real-time unit stick until software clears them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rt_fault_r <= '0;
      end else begin
         for (int j = 0; j < NRT; j++) begin
            rt_fault_r[j] <= (rt_fault_r[j] & ~rt_fault_clear[j])
               | (elig[RT_UNIT[j]] && wait_r[RT_UNIT[j]] > rt_latency_limit[j]);
         end
      end
   end

   assign grant = grant_r;
   assign ack = ack_r;
   assign done = done_r;
   assign refresh_active = state_r == ST_REFRESH;
   assign rt_fault = rt_fault_r;

   // ==================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_plain_start;
      grant_r.valid && len_r == TXN_CYCLES;
   endsequence
   sequence s_long_start;
      grant_r.valid && len_r != TXN_CYCLES;
   endsequence

   property p_xfer_len;
      s_plain_start |-> ##20 (done_r != '0);
   endproperty
   a_xfer_len: assert property (p_xfer_len) else $error("transaction not 20 cycles");

   property p_reorder_len;
      s_long_start |-> ##30 (done_r != '0);
   endproperty
   a_reorder_len: assert property (p_reorder_len) else $error("reorder not +10");

   property p_refresh_len;
      $rose(refresh_active) |-> ##18 refresh_active ##1 !refresh_active;
   endproperty
   a_refresh_len: assert property (p_refresh_len) else $error("refresh not 19 cycles");

   property p_one_ack;
      (ack_r != '0) |-> $onehot(ack_r) && !$past(next_v_r);
   endproperty
   a_one_ack: assert property (p_one_ack) else $error("bad acknowledge");

   property p_disabled;
      (ack_r != '0) |-> (ack_r & ~$past(unit_enable)) == '0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled unit granted");

   property p_promo_first;
      (decide_now && promo != '0) |=> (ack_r & $past(promo)) != '0;
   endproperty
   a_promo_first: assert property (p_promo_first) else $error("raised request lost");

   property p_lone;
      (decide_now && $onehot(elig)) |=> ack_r == $past(elig);
   endproperty
   a_lone: assert property (p_lone) else $error("idle bandwidth withheld");

   property p_fault;
      (elig[U_AIN] && wait_r[U_AIN] > rt_latency_limit[2]) |=> rt_fault_r[2];
   endproperty
   a_fault: assert property (p_fault) else $error("late grant not flagged");

   property p_no_repeat;
      inflight_r[U_AIN] |=> !ack_r[U_AIN];
   endproperty
   a_no_repeat: assert property (p_no_repeat) else $error("outstanding unit regranted");

endmodule : hwa_arbiter

// ===== hwa_req_model.sv
// Requester side model: one request per wanted unit, held off until done (the processor is never held off).
// Assumes ack and done are one-cycle pulses from the arbiter.
module hwa_req_model
   import hwa_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic [NUNITS-1:0] want,
   input logic [NUNITS-1:0] ack,
   input logic [NUNITS-1:0] done,
   output logic [NUNITS-1:0] req
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [NUNITS-1:0] wait_r;
   // ==========================================================
   // Outstanding transaction per unit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_r <= '0;
      end else begin
         wait_r <= (wait_r | ack) & ~done & ~BACK2BACK;
      end
   end
   // Processor may keep asking; others wait for their data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req <= '0;
      end else begin
         req <= want & (BACK2BACK | ~(wait_r | ack));
      end
   end
endmodule : hwa_req_model

// ===== testbench.sv
// Self-checking bench for the memory arbiter: timing, refresh, faults.
// Assumes one 200 MHz clock; inputs change on the falling edge.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import hwa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [NUNITS-1:0] want = '0;
   logic [NUNITS-1:0] en = '1;
   logic [NUNITS-1:0] req;
   logic [NUNITS-1:0] ack;
   logic [NUNITS-1:0] done;
   logic cpu_reorder = 1'b0;
   logic [NUNITS-1:0] wr = '0;
   logic [NRAISE-1:0][7:0] rd = '0;
   hwa_ratio_e ratio = HWA_R1;
   logic [NRT-1:0][WAIT_W-1:0] lim = '1;
   logic [NRT-1:0] clr = '0;
   logic [NRT-1:0] rt_fault;
   logic refresh_active;
   hwa_grant_s grant;
   int fails = 0;
   int num_checks = 0;
   always #2.5 clk = ~clk;
   hwa_req_model u_req (.clk(clk), .rst(rst), .want(want), .ack(ack), .done(done), .req(req));
   hwa_arbiter dut (.clk(clk), .rst(rst), .req(req), .req_write(wr),
      .cpu_reorder(cpu_reorder), .unit_enable(en), .bandwidth_weight_reg('0),
      .priority_raise_delay_reg(rd), .clk_ratio(ratio), .rt_latency_limit(lim),
      .rt_fault_clear(clr), .grant(grant), .ack(ack), .done(done),
      .refresh_active(refresh_active), .rt_fault(rt_fault));
   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle
   task automatic end_sim();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   // ==========================================================
   // Scenarios
   task automatic txn(input int u, input int gap);
      int n;
      want[u] = 1'b1;
      for (n = 0; n < 200 && grant.valid !== 1'b1; n++) settle();
      check(grant.unit, u);
      check(grant.write, wr[u]);
      check(grant.bytes, BLOCK_BYTES);
      @(negedge clk);
      want[u] = 1'b0;
      for (n = 0; n < 200 && done[u] !== 1'b1; n++) settle();
      check(n, gap);
      @(negedge clk);
      $display("txn test done");
   endtask : txn
   task automatic t_prom(input logic [7:0] dly, input hwa_ratio_e r,
      input logic [UID_W-1:0] who);
      int n;
      rd[1] = dly;
      ratio = r;
      want[U_ICOP] = 1'b1;
      want[U_VIN] = 1'b1;
      for (n = 0; n < 200 && grant.valid !== 1'b1; n++) settle();
      check(grant.unit, who);
      @(negedge clk);
      want = '0;
      cyc(60);
      $display("promotion test done");
   endtask : t_prom
   task automatic t_off();
      int n;
      n = 0;
      en[9] = 1'b0;
      want[9] = 1'b1;
      repeat (60) begin
         settle();
         if (ack[9] !== 1'b0) n++;
      end
      @(negedge clk);
      want[9] = 1'b0;
      cyc(2);
      en[9] = 1'b1;
      check(n, 0);
      $display("disable test done");
   endtask : t_off
   task automatic t_fault();
      lim[2] = 14'h0002;
      want[0] = 1'b1;
      cyc(2);
      want[0] = 1'b0;
      want[6] = 1'b1;
      cyc(60);
      want[6] = 1'b0;
      check(rt_fault[2], 1'b1);
      clr[2] = 1'b1;
      cyc(1);
      clr[2] = 1'b0;
      cyc(1);
      check(rt_fault[2], 1'b0);
      $display("fault test done");
   endtask : t_fault
   task automatic t_refresh();
      int n;
      for (n = 0; n < 4000 && refresh_active !== 1'b1; n++) settle();
      for (n = 0; n < 50 && refresh_active === 1'b1; n++) settle();
      check(n, 19);
      $display("refresh test done");
   endtask : t_refresh
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      cyc(3);
      rst = 1'b0;
      cyc(2);
      txn(1, 20);
      cyc(5);
      cpu_reorder = 1'b1;
      wr[0] = 1'b1;
      txn(0, 30);
      cpu_reorder = 1'b0;
      cyc(50);
      t_prom(8'h00, HWA_R1, U_VIN);
      t_off();
      t_fault();
      t_prom(8'h01, HWA_R2_1, U_ICOP);
      t_refresh();
      end_sim();
   end
   initial begin
      #60000;
      fails++;
      $display("watchdog expired");
      end_sim();
   end
endmodule : testbench
